/* File: core/asbp_pkg.sv */
// constants and carrier types for the byte-wide static ram host controller
// assumes a 20 MHz system clock and an asynchronous sram on the pins
// How it works
// - write ends when any qualifier leaves; we end it with the strobe
// - data is held stable across the strobe's rising edge
// - host drives data only while output gate is high
// - strobe pulse covers turn-off plus data setup time
// - first access waits at least 100 us after power-up
// - address and selects valid 7 ns before write end
// - strobe stays high through every read cycle
package asbp_pkg;
   localparam int ASBP_CLK_MHZ = 20;
   localparam int ASBP_PERIOD_NS = 1000 / ASBP_CLK_MHZ;
   localparam int ASBP_ADDR_W = 17;
   localparam int ASBP_DATA_W = 8;
   localparam int ASBP_WAIT_US = 100;
   localparam int ASBP_WAIT_CYC = ASBP_WAIT_US * ASBP_CLK_MHZ;
   localparam int ASBP_TAA_NS = 10;
   localparam int ASBP_TDOE_NS = 5;
   localparam int ASBP_THZWE_NS = 5;
   localparam int ASBP_TSD_NS = 6;
   localparam int ASBP_TAW_NS = 7;
   localparam int ASBP_TPWE_NS = 7;
   localparam int ASBP_RD_CYC = (ASBP_TAA_NS + ASBP_PERIOD_NS - 1) / ASBP_PERIOD_NS;
   localparam int ASBP_OE_CYC = (ASBP_TDOE_NS + ASBP_PERIOD_NS - 1) / ASBP_PERIOD_NS;
   localparam int ASBP_WR_CYC =
      (ASBP_THZWE_NS + ASBP_TSD_NS + ASBP_PERIOD_NS - 1) / ASBP_PERIOD_NS;
   localparam int ASBP_AW_CYC = (ASBP_TAW_NS + ASBP_PERIOD_NS - 1) / ASBP_PERIOD_NS;
   localparam int ASBP_CNT_W = 16;

   typedef struct packed {
      logic write;
      logic [ASBP_ADDR_W-1:0] addr;
      logic [ASBP_DATA_W-1:0] wdata;
   } asbp_req_s;

   typedef struct packed {
      logic selLowActiveN;
      logic selHighActive;
      logic outGateN;
      logic writeStrobeN;
      logic [ASBP_ADDR_W-1:0] addr;
   } asbp_pins_s;

   typedef enum logic [2:0] {
      ASBP_POWER = 3'b000,
      ASBP_IDLE = 3'b001,
      ASBP_READ = 3'b010,
      ASBP_WSET = 3'b011,
      ASBP_WPULSE = 3'b100,
      ASBP_WEND = 3'b101
   } asbp_state_e;
endpackage

/* File: core/async_sram_byte_port.sv */
// host controller that runs single-byte reads and writes on an async sram
// assumes the sram pins are timed by this 20 MHz clock and a settled supply
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_port #(
   parameter int POWER_WAIT = asbp_pkg::ASBP_WAIT_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // user request
   input wire logic reqValid,
   input wire asbp_pkg::asbp_req_s req,
   output logic reqReady,
   output logic rspValid,
   output logic [asbp_pkg::ASBP_DATA_W-1:0] rspData,
   // sram pins
   output asbp_pkg::asbp_pins_s pins,
   input wire logic [asbp_pkg::ASBP_DATA_W-1:0] sharedDataPinsIn,
   output logic [asbp_pkg::ASBP_DATA_W-1:0] sharedDataPinsOut,
   output logic sharedDataPinsOe
);
   import asbp_pkg::*;

   // reset release through two flops
   logic rstSync1, rstSync2;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   asbp_state_e state, next_state;
   logic [ASBP_CNT_W-1:0] count, next_count;
   asbp_pins_s next_pins;
   logic [ASBP_DATA_W-1:0] next_dout, next_rspData;
   logic next_oe, next_reqReady, next_rspValid;
   localparam asbp_pins_s PINS_IDLE = '{selLowActiveN: 1'b1, selHighActive: 1'b0,
      outGateN: 1'b1, writeStrobeN: 1'b1, addr: '0};

   always_comb begin
      next_state = state;
      next_count = count;
      next_pins = pins;
      next_dout = sharedDataPinsOut;
      next_oe = sharedDataPinsOe;
      next_rspData = rspData;
      next_rspValid = 1'b0;
      next_reqReady = 1'b0;
      case (state)
         ASBP_POWER: begin
            next_count = count + 1'b1;
            if (count >= ASBP_CNT_W'(POWER_WAIT - 1)) begin
               next_state = ASBP_IDLE;
               next_reqReady = 1'b1;
            end
         end
         ASBP_IDLE: begin
            next_pins = PINS_IDLE;
            next_oe = 1'b0;
            next_reqReady = 1'b1;
            if (reqValid && reqReady) begin
               next_reqReady = 1'b0;
               next_count = '0;
               next_pins.selLowActiveN = 1'b0;
               next_pins.selHighActive = 1'b1;
               next_pins.addr = req.addr;
               if (req.write) begin
                  next_pins.outGateN = 1'b1;
                  next_dout = req.wdata;
                  next_oe = 1'b1;
                  next_state = ASBP_WSET;
               end else begin
                  next_pins.outGateN = 1'b0;
                  next_pins.writeStrobeN = 1'b1;
                  next_state = ASBP_READ;
               end
            end
         end
         ASBP_READ: begin
            next_count = count + 1'b1;
            if (count >= ASBP_CNT_W'(((ASBP_RD_CYC > ASBP_OE_CYC) ?
                  ASBP_RD_CYC : ASBP_OE_CYC) - 1)) begin
               next_rspData = sharedDataPinsIn;
               next_rspValid = 1'b1;
               next_pins = PINS_IDLE;
               next_state = ASBP_IDLE;
            end
         end
         ASBP_WSET: begin
            next_pins.writeStrobeN = 1'b0;
            next_count = '0;
            next_state = ASBP_WPULSE;
         end
         ASBP_WPULSE: begin
            next_count = count + 1'b1;
            if (count >= ASBP_CNT_W'(ASBP_WR_CYC - 1) &&
                  count >= ASBP_CNT_W'(ASBP_AW_CYC - 1)) begin
               next_pins.writeStrobeN = 1'b1;
               next_state = ASBP_WEND;
            end
         end
         ASBP_WEND: begin
            next_pins = PINS_IDLE;
            next_oe = 1'b0;
            next_rspValid = 1'b1;
            next_state = ASBP_IDLE;
         end
         default: begin
            next_state = ASBP_IDLE;
            next_pins = PINS_IDLE;
            next_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstSync2) begin
      if (!rstSync2) begin
         state <= ASBP_POWER;
         count <= '0;
         pins <= PINS_IDLE;
         sharedDataPinsOut <= '0;
         sharedDataPinsOe <= 1'b0;
         rspData <= '0;
         rspValid <= 1'b0;
         reqReady <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         pins <= next_pins;
         sharedDataPinsOut <= next_dout;
         sharedDataPinsOe <= next_oe;
         rspData <= next_rspData;
         rspValid <= next_rspValid;
         reqReady <= next_reqReady;
      end
   end

   // cycles since reset release, read only by the checks
   logic [ASBP_CNT_W-1:0] upCount, next_upCount;
   always_comb begin
      next_upCount = upCount;
      if (upCount != '1) begin
         next_upCount = upCount + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstSync2) begin
      if (!rstSync2) begin
         upCount <= '0;
      end else begin
         upCount <= next_upCount;
      end
   end

   // cycles the strobe has been low, read only by the checks
   logic [ASBP_CNT_W-1:0] lowCount, next_lowCount;
   always_comb begin
      next_lowCount = lowCount;
      if (pins.writeStrobeN) begin
         next_lowCount = '0;
      end else if (lowCount != '1) begin
         next_lowCount = lowCount + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstSync2) begin
      if (!rstSync2) begin
         lowCount <= '0;
      end else begin
         lowCount <= next_lowCount;
      end
   end

   // pin protocol checks
   AST_WRITE_QUAL: assert property (@(posedge clock) disable iff (!rstSync2)
      !pins.writeStrobeN |-> (!pins.selLowActiveN && pins.selHighActive))
      else $error("strobe low without both selects");
   AST_SEL_AFTER_STROBE: assert property (@(posedge clock) disable iff (!rstSync2)
      $rose(pins.writeStrobeN) |-> !pins.selLowActiveN ##1 pins.selLowActiveN)
      else $error("select not held one cycle past strobe");
   AST_GATE_IN_WRITE: assert property (@(posedge clock) disable iff (!rstSync2)
      !pins.writeStrobeN |-> pins.outGateN)
      else $error("output gate low during write");
   AST_NO_CONTENTION: assert property (@(posedge clock) disable iff (!rstSync2)
      sharedDataPinsOe |-> pins.outGateN)
      else $error("host drives while memory may drive");
   AST_OE_SELECTED: assert property (@(posedge clock) disable iff (!rstSync2)
      sharedDataPinsOe |-> !pins.selLowActiveN && pins.selHighActive)
      else $error("host drives while memory deselected");
   AST_PULSE_WIDTH: assert property (@(posedge clock) disable iff (!rstSync2)
      $rose(pins.writeStrobeN) |->
         int'(lowCount) * ASBP_PERIOD_NS >= ASBP_THZWE_NS + ASBP_TSD_NS &&
         int'(lowCount) * ASBP_PERIOD_NS >= ASBP_TPWE_NS)
      else $error("strobe pulse too short");
   AST_DATA_HOLD: assert property (@(posedge clock) disable iff (!rstSync2)
      $rose(pins.writeStrobeN) |-> sharedDataPinsOe && $stable(sharedDataPinsOut))
      else $error("data moved at write end");
   AST_WRITE_END: assert property (@(posedge clock) disable iff (!rstSync2)
      $rose(pins.writeStrobeN) |-> ##1 (pins.selLowActiveN && !sharedDataPinsOe))
      else $error("write not closed after strobe");
   AST_ADDR_STEADY: assert property (@(posedge clock) disable iff (!rstSync2)
      !pins.writeStrobeN |-> $stable(pins.addr) && $stable(pins.selLowActiveN))
      else $error("address or select moved during write");
   AST_SETUP_TIME: assert property (@(posedge clock) disable iff (!rstSync2)
      $rose(pins.writeStrobeN) |-> int'(lowCount) * ASBP_PERIOD_NS >= ASBP_TAW_NS)
      else $error("write end too close to setup");
   AST_POWER_WAIT: assert property (@(posedge clock) disable iff (!rstSync2)
      !pins.selLowActiveN |-> upCount >= ASBP_CNT_W'(POWER_WAIT))
      else $error("access before power-up wait");
   AST_READY_AFTER_WAIT: assert property (@(posedge clock) disable iff (!rstSync2)
      reqReady |-> upCount >= ASBP_CNT_W'(POWER_WAIT))
      else $error("ready before power-up wait");
   AST_READ_STROBE: assert property (@(posedge clock) disable iff (!rstSync2)
      !pins.outGateN |-> pins.writeStrobeN)
      else $error("strobe low during read");
   AST_IDLE_DESEL: assert property (@(posedge clock) disable iff (!rstSync2)
      state == ASBP_IDLE |-> pins.selLowActiveN && !sharedDataPinsOe)
      else $error("idle bus left selected");
endmodule
`default_nettype wire

/* File: verification/asbp_sram_model.sv */
// behavioural byte-wide static ram standing on the controller's pins
// assumes the bench resolves the shared data bus from the host's enable alone
`timescale 1ns/1ps
`default_nettype none
module asbp_sram_model (
   // control and address pins
   input wire asbp_pkg::asbp_pins_s pins,
   input wire logic [asbp_pkg::ASBP_DATA_W-1:0] busIn,
   // memory side of the data pins
   output logic [asbp_pkg::ASBP_DATA_W-1:0] dataOut,
   output logic drive
);
   import asbp_pkg::*;
   // contents kept whether selected or not
   logic [ASBP_DATA_W-1:0] mem [0:(1<<ASBP_ADDR_W)-1];
   logic [ASBP_DATA_W-1:0] readVal;
   logic sel;
   logic wrAct;
   assign sel = !pins.selLowActiveN && pins.selHighActive;
   assign wrAct = sel && !pins.writeStrobeN;
   assign #(ASBP_TAA_NS) readVal = mem[pins.addr];
   assign #(ASBP_TDOE_NS) drive = sel && !pins.outGateN && pins.writeStrobeN;
   initial begin
      dataOut = 8'h5A;
      for (int i = 0; i < (1 << ASBP_ADDR_W); i++) begin
         mem[i] = 8'h00;
      end
   end
   always @* begin
      if (wrAct) begin
         mem[pins.addr] = busIn;
      end
   end
   // released pins show the inverse of the last value
   always @(drive, readVal) begin
      if (drive) begin
         dataOut = readVal;
      end else begin
         dataOut = ~dataOut;
      end
   end
endmodule
`default_nettype wire

/* File: verification/async_sram_byte_port_tb_top.sv */
// self-checking bench for the async sram host controller
// assumes the behavioural memory model and a shortened power-up wait
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_port_tb_top;
   import asbp_pkg::*;
   localparam int WAIT = 8;
   logic clock, nrst, reqValid, reqReady, rspValid, pinsOe, memDrive, prevStrobeN;
   asbp_req_s req;
   asbp_pins_s pins;
   logic [ASBP_DATA_W-1:0] rspData, pinsOut, memOut, busLevel, q;
   int nErrors, checkCount, lat;
   assign busLevel = pinsOe ? pinsOut : memOut;
   async_sram_byte_port #(.POWER_WAIT(WAIT)) dut (.clock(clock), .nrst(nrst),
      .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
      .rspData(rspData), .pins(pins), .sharedDataPinsIn(busLevel),
      .sharedDataPinsOut(pinsOut), .sharedDataPinsOe(pinsOe));
   asbp_sram_model sram (.pins(pins), .busIn(busLevel), .dataOut(memOut), .drive(memDrive));
   task automatic check_flag(input logic ok, input string what);
      checkCount++;
      if (ok !== 1'h1) begin
         nErrors++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask
   task automatic check_data(input logic [ASBP_DATA_W-1:0] got, exp, input string what);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic xfer(input logic wr, input logic [ASBP_ADDR_W-1:0] a,
         input logic [ASBP_DATA_W-1:0] d);
      lat = 0;
      while (reqReady !== 1'h1 && lat < 50) begin
         @(posedge clock);
         #1;
         lat++;
      end
      reqValid = 1'h1;
      req = '{wr, a, d};
      @(posedge clock);
      #1;
      reqValid = 1'h0;
      lat = 0;
      while (rspValid !== 1'h1 && lat < 20) begin
         @(posedge clock);
         #1;
         lat++;
      end
      q = rspData;
   endtask
   task automatic t_power;
      int k;
      check_flag(pins.selLowActiveN && !pins.selHighActive && pins.outGateN
         && pins.writeStrobeN && !pinsOe && !reqReady, "idle in reset");
      #1;
      nrst = 1'h1;
      reqValid = 1'h1;
      req = '{1'h1, 17'h00005, 8'hAA};
      k = 0;
      while (reqReady !== 1'h1 && k < 100) begin
         @(posedge clock);
         #1;
         k++;
         if (k == 3) reqValid = 1'h0;
      end
      check_flag(k == WAIT + 2, "first access wait");
      $display("power test done");
   endtask
   task automatic t_write_read;
      logic [ASBP_ADDR_W-1:0] a [3] = '{17'h00000, 17'h1FFFF, 17'h0A5A5};
      logic [ASBP_DATA_W-1:0] d [3] = '{8'h3C, 8'hC3, 8'h5A};
      for (int i = 0; i < 3; i++) begin
         xfer(1'h1, a[i], d[i]);
         check_flag(lat == 3, "write latency");
      end
      for (int i = 0; i < 3; i++) begin
         xfer(1'h0, a[i], 8'h00);
         check_flag(lat == 1, "read latency");
         check_data(q, d[i], "read back");
      end
      xfer(1'h0, 17'h00005, 8'h00);
      check_data(q, 8'h00, "refused write");
      $display("write read test done");
   endtask
   task automatic t_retention;
      repeat (20) @(posedge clock);
      #1;
      check_flag(pins.selLowActiveN && !memDrive, "standby");
      xfer(1'h0, 17'h1FFFF, 8'h00);
      check_data(q, 8'hC3, "retained");
      $display("retention test done");
   endtask
   always @(negedge clock) begin
      if (nrst === 1'h1) begin
         check_flag(!(pinsOe && memDrive), "bus contention");
         if (pins.writeStrobeN === 1'h0)
            check_flag(pins.outGateN && pinsOe && !pins.selLowActiveN, "write");
         if (pins.outGateN === 1'h0)
            check_flag(pins.writeStrobeN, "strobe in read");
         if (prevStrobeN === 1'h0 && pins.writeStrobeN === 1'h1)
            check_flag(!pins.selLowActiveN, "select at write end");
      end
      prevStrobeN <= pins.writeStrobeN;
   end
   initial begin
      clock = 1'h0;
      forever #(ASBP_PERIOD_NS / 2) clock = ~clock;
   end
   initial begin
      #(3000 * ASBP_PERIOD_NS);
      nErrors++;
      $display("ERROR %0t watchdog", $time);
      report_and_stop;
   end
   initial begin
      nrst = 1'h0;
      reqValid = 1'h0;
      req = '0;
      prevStrobeN = 1'h1;
      repeat (16) @(posedge clock);
      t_power;
      t_write_read;
      t_retention;
      report_and_stop;
   end
endmodule
`default_nettype wire
